// *** logic/ulpirr_core.sv ***
`timescale 1ns/100ps
`include "ulpirr_defines.svh"

module ulpirr_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Interface pins
	input wire logic stp,
	output logic dir,
	output logic nxt,
	input wire logic [`ULPIRR_W-1:0] dataIn,
	output logic [`ULPIRR_W-1:0] dataOut,
	output logic dataOeN,
	// Start-up and mode exit
	input wire logic clkStable,
	input wire logic asyncExit,
	// Status pins, asynchronous
	input wire ulpirr_pkg::ulpirr_status_s statusPins,
	// Receive path
	input wire ulpirr_pkg::ulpirr_rxev_s rxEvents,
	input wire logic rxByteValid,
	input wire logic [`ULPIRR_W-1:0] rxByte,
	// Transmit path
	input wire logic txActive,
	input wire logic txHs,
	// Register file read port
	output logic regRd,
	output logic regExt,
	output logic [`ULPIRR_W-1:0] regAddr,
	input wire logic [`ULPIRR_W-1:0] regRdData
);

	ulpirr_pkg::ulpirr_core_s q;
	ulpirr_pkg::ulpirr_core_s d;
	logic [`ULPIRR_W-1:0] statusByte;
	logic statusChg;
	logic cmdRead;
	logic cmdExt;
	logic txBlock;
	logic pendSet;
	logic pendClr;
	logic busIdle;

	// ============================================================
	// Status synchronisation and encoding
	ulpirr_status_enc u_enc (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.statusPins(statusPins),
		.rxEvents(rxEvents),
		.statusByte(statusByte),
		.statusChg(statusChg)
	);

	// ============================================================
	// Decodes
	assign cmdRead = (dataIn[`ULPIRR_CMD_MSB:`ULPIRR_CMD_LSB] ==
		`ULPIRR_CMD_READ);
	assign cmdExt = (dataIn[`ULPIRR_ADR_MSB:`ULPIRR_ADR_LSB] ==
		`ULPIRR_EXT_ESC);
	// High speed holds status until the packet ends; others until stop.
	assign txBlock = txActive && (txHs || !stp);
	assign busIdle = (dataIn == `ULPIRR_IDLE_CMD);

	// ============================================================
	// Pin outputs
	always_comb begin
		case (q.state)
			ulpirr_pkg::ST_BOOT,
			ulpirr_pkg::ST_TURN,
			ulpirr_pkg::ST_DATA,
			ulpirr_pkg::ST_RXC_TURN,
			ulpirr_pkg::ST_RXC_SEND,
			ulpirr_pkg::ST_RX_TURN,
			ulpirr_pkg::ST_RX: begin
				dir = 1'b1;
			end
			default: begin
				dir = 1'b0;
			end
		endcase
		case (q.state)
			ulpirr_pkg::ST_DATA,
			ulpirr_pkg::ST_RXC_SEND,
			ulpirr_pkg::ST_RX: begin
				dataOeN = 1'b0;
			end
			default: begin
				dataOeN = 1'b1;
			end
		endcase
	end

	assign nxt = q.nxt;
	assign dataOut = q.dataOut;
	assign regAddr = q.addr;
	assign regExt = q.ext;
	assign regRd = (q.state == ulpirr_pkg::ST_TURN);

	// ============================================================
	// Pending status byte: a new event wins over the clear
	assign pendSet = statusChg ||
		(q.bootPend && q.state == ulpirr_pkg::ST_IDLE && !stp);

	always_comb begin
		d = q;
		pendClr = 1'b0;
		d.nxt = 1'b0;
		if (asyncExit) begin
			d.bootPend = 1'b1;
		end else if (pendSet && !statusChg) begin
			d.bootPend = 1'b0;
		end
		case (q.state)
			ulpirr_pkg::ST_BOOT: begin
				if (clkStable) begin
					d.state = ulpirr_pkg::ST_BACK;
				end
			end
			ulpirr_pkg::ST_IDLE: begin
				if (rxEvents.rxActive) begin
					d.nxt = 1'b1;
					d.state = ulpirr_pkg::ST_RX_TURN;
				end else if (cmdRead) begin
					d.state = ulpirr_pkg::ST_CMD;
				end else if (q.pending && !txBlock && busIdle) begin
					d.state = ulpirr_pkg::ST_RXC_TURN;
				end
			end
			ulpirr_pkg::ST_CMD: begin
				d.nxt = 1'b1;
				d.state = ulpirr_pkg::ST_ACK;
			end
			ulpirr_pkg::ST_ACK: begin
				d.ext = cmdExt;
				d.addr = `ULPIRR_W'(dataIn[`ULPIRR_ADR_MSB:`ULPIRR_ADR_LSB]);
				if (cmdExt) begin
					d.nxt = 1'b1;
					d.state = ulpirr_pkg::ST_EXTA;
				end else begin
					d.state = ulpirr_pkg::ST_TURN;
				end
			end
			ulpirr_pkg::ST_EXTA: begin
				d.addr = dataIn;
				d.state = ulpirr_pkg::ST_TURN;
			end
			ulpirr_pkg::ST_TURN: begin
				d.dataOut = regRdData;
				d.state = ulpirr_pkg::ST_DATA;
			end
			ulpirr_pkg::ST_DATA: begin
				d.dataOut = `ULPIRR_IDLE_CMD;
				d.state = ulpirr_pkg::ST_BACK;
			end
			ulpirr_pkg::ST_BACK: begin
				// The bus is not looked at in this turnaround cycle.
				d.state = ulpirr_pkg::ST_IDLE;
			end
			ulpirr_pkg::ST_RXC_TURN: begin
				d.dataOut = statusByte;
				pendClr = 1'b1;
				d.state = ulpirr_pkg::ST_RXC_SEND;
			end
			ulpirr_pkg::ST_RXC_SEND: begin
				if (rxEvents.rxActive) begin
					d.nxt = 1'b1;
					d.dataOut = `ULPIRR_IDLE_CMD;
					d.state = ulpirr_pkg::ST_RX;
				end else if (q.pending) begin
					d.dataOut = statusByte;
					pendClr = 1'b1;
				end else begin
					d.dataOut = `ULPIRR_IDLE_CMD;
					d.state = ulpirr_pkg::ST_BACK;
				end
			end
			ulpirr_pkg::ST_RX_TURN,
			ulpirr_pkg::ST_RX: begin
				if (!rxEvents.rxActive) begin
					d.dataOut = statusByte;
					pendClr = 1'b1;
					d.state = ulpirr_pkg::ST_RXC_SEND;
				end else if (rxByteValid) begin
					d.nxt = 1'b1;
					d.dataOut = rxByte;
					d.state = ulpirr_pkg::ST_RX;
				end else begin
					d.dataOut = statusByte;
					pendClr = 1'b1;
					d.state = ulpirr_pkg::ST_RX;
				end
			end
			default: begin
				d.state = ulpirr_pkg::ST_IDLE;
			end
		endcase
		d.pending = (q.pending && !pendClr) || pendSet;
	end

	// All state moves on the rising edge only.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			q <= '0;
			q.state <= ulpirr_pkg::ST_BOOT;
			q.bootPend <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// ============================================================
	// Checks
	a_nxt_ack: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_IDLE && cmdRead &&
		!rxEvents.rxActive) |=> !nxt ##1 nxt)
		else $error("Next not raised one cycle after the read command.");

	a_dir_take: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_ACK && !cmdExt) |=>
		(dir && !nxt && dataOeN))
		else $error("Direction not taken with next dropped.");

	a_read_data: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		regRd |=> (dir && !dataOeN && dataOut == $past(regRdData))
		##1 !dir)
		else $error("Register data not driven for one cycle.");

	a_ext_seq: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_ACK && cmdExt) |=> nxt && !dir
		##1 (dir && !nxt && regAddr == $past(dataIn))
		##1 (dir && !dataOeN) ##1 !dir)
		else $error("Extended read sequence broken.");

	a_rxc_fresh: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		($rose(dir) && q.state == ulpirr_pkg::ST_RXC_TURN) |=>
		(!dataOeN && !nxt && dataOut == $past(statusByte)))
		else $error("Status byte not current when sent.");

	a_rx_status: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_RX && rxEvents.rxActive &&
		!rxByteValid) |=> (dir && !nxt && dataOut == $past(statusByte)))
		else $error("No status byte in a receive gap.");

	a_hs_hold: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_IDLE && txActive && txHs &&
		!rxEvents.rxActive) |=> !dir)
		else $error("Status byte sent during high speed transmit.");

	a_turn_quiet: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		($rose(dir) || $fell(dir)) |-> dataOeN)
		else $error("Data driven in a turnaround cycle.");

	a_boot_status: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.bootPend && !q.pending && !stp &&
		q.state == ulpirr_pkg::ST_IDLE && !rxEvents.rxActive &&
		!cmdRead && busIdle && !txActive)
		|=> ##2 (dir && !dataOeN))
		else $error("No status byte after start-up.");

	a_event_kept: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		statusChg |=> q.pending)
		else $error("Status change lost.");

	a_imm_addr: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_ACK && !cmdExt) |=>
		(regRd && !regExt &&
		regAddr[`ULPIRR_W-1:`ULPIRR_CMD_LSB] == '0 &&
		regAddr[`ULPIRR_ADR_MSB:`ULPIRR_ADR_LSB] ==
		$past(dataIn[`ULPIRR_ADR_MSB:`ULPIRR_ADR_LSB])))
		else $error("Immediate register address not captured.");

	a_rx_take: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_IDLE && rxEvents.rxActive) |=>
		(dir && nxt && dataOeN))
		else $error("Receive turnaround not signalled.");

	a_rx_byte: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_RX && rxEvents.rxActive &&
		rxByteValid) |=> (dir && nxt && !dataOeN &&
		dataOut == $past(rxByte)))
		else $error("Received byte not passed with next.");

	a_rx_end: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_RX && !rxEvents.rxActive) |=>
		(dir && !nxt && !dataOeN && dataOut == $past(statusByte)))
		else $error("No closing status byte after receive.");

	a_turn_back: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		$fell(dir) |=> (q.state == ulpirr_pkg::ST_IDLE))
		else $error("Turnaround after release not one cycle.");

	a_fs_hold: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		(q.state == ulpirr_pkg::ST_IDLE && txActive && !txHs &&
		!stp && !rxEvents.rxActive) |=> !dir)
		else $error("Status byte sent in transmit before stop.");

	a_rd_single: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		regRd |=> !regRd)
		else $error("Register read strobe longer than one cycle.");

endmodule

// *** logic/ulpirr_defines.svh ***
`ifndef ULPIRR_DEFINES_SVH
`define ULPIRR_DEFINES_SVH

// ============================================================
// Bus widths
`define ULPIRR_W 8
`define ULPIRR_SW 6

// ============================================================
// Command byte layout and codes
`define ULPIRR_CMD_MSB 7
`define ULPIRR_CMD_LSB 6
`define ULPIRR_ADR_MSB 5
`define ULPIRR_ADR_LSB 0
`define ULPIRR_CMD_READ 2'h3
`define ULPIRR_EXT_ESC 6'h2F
`define ULPIRR_IDLE_CMD 8'h00

// ============================================================
// Receive command byte layout
`define ULPIRR_LS_MSB 1
`define ULPIRR_LS_LSB 0
`define ULPIRR_VB_MSB 3
`define ULPIRR_VB_LSB 2
`define ULPIRR_EV_MSB 5
`define ULPIRR_EV_LSB 4
`define ULPIRR_ID_BIT 6
`define ULPIRR_ALT_BIT 7

// ============================================================
// Receive command codes
`define ULPIRR_VB_LOW 2'h0
`define ULPIRR_VB_SESS 2'h1
`define ULPIRR_VB_SVLD 2'h2
`define ULPIRR_VB_VVLD 2'h3
`define ULPIRR_EV_IDLE 2'h0
`define ULPIRR_EV_ACT 2'h1
`define ULPIRR_EV_DISC 2'h2
`define ULPIRR_EV_ERR 2'h3

// ============================================================
// Positions in the synchronised status vector
`define ULPIRR_S_LS_MSB 1
`define ULPIRR_S_LS_LSB 0
`define ULPIRR_S_SEND 2
`define ULPIRR_S_SVLD 3
`define ULPIRR_S_VVLD 4
`define ULPIRR_S_ID 5

`endif

// *** logic/ulpirr_pkg.sv ***
package ulpirr_pkg;

`include "ulpirr_defines.svh"

// ============================================================
// Carriers
typedef struct packed {
	logic idPin;
	logic vbusVld;
	logic sessVld;
	logic sessEnd;
	logic [1:0] lineState;
} ulpirr_status_s;

typedef struct packed {
	logic rxActive;
	logic rxError;
	logic hostDisc;
	logic altInt;
} ulpirr_rxev_s;

// ============================================================
// State
typedef enum logic [3:0] {
	ST_BOOT,
	ST_IDLE,
	ST_CMD,
	ST_ACK,
	ST_EXTA,
	ST_TURN,
	ST_DATA,
	ST_BACK,
	ST_RXC_TURN,
	ST_RXC_SEND,
	ST_RX_TURN,
	ST_RX
} ulpirr_state_e;

typedef struct packed {
	ulpirr_state_e state;
	logic [`ULPIRR_W-1:0] dataOut;
	logic [`ULPIRR_W-1:0] addr;
	logic ext;
	logic nxt;
	logic pending;
	logic bootPend;
} ulpirr_core_s;

typedef struct packed {
	logic [`ULPIRR_SW-1:0] s1;
	logic [`ULPIRR_SW-1:0] s2;
	logic [`ULPIRR_SW-1:0] s3;
	logic [`ULPIRR_SW-1:0] stable;
} ulpirr_sync_s;

endpackage

// *** logic/ulpirr_status_enc.sv ***
`timescale 1ns/100ps
`include "ulpirr_defines.svh"

module ulpirr_status_enc (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Status pins, asynchronous
	input wire ulpirr_pkg::ulpirr_status_s statusPins,
	// Receive events on this clock
	input wire ulpirr_pkg::ulpirr_rxev_s rxEvents,
	// Encoded status
	output logic [`ULPIRR_W-1:0] statusByte,
	output logic statusChg
);

	ulpirr_pkg::ulpirr_sync_s st_q;
	ulpirr_pkg::ulpirr_sync_s st_d;
	logic [`ULPIRR_SW-1:0] agreed;
	logic [1:0] vbCode;
	logic [1:0] evCode;

	// ============================================================
	// Synchroniser: a change counts once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < `ULPIRR_SW; i++) begin : g_agree
			assign agreed[i] = (st_q.s2[i] == st_q.s3[i]) ?
				st_q.s3[i] : st_q.stable[i];
		end
	endgenerate

	always_comb begin
		st_d = st_q;
		st_d.s1 = statusPins;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.stable = agreed;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign statusChg = (agreed != st_q.stable);

	// ============================================================
	// Encoding of the receive command byte
	always_comb begin
		if (st_q.stable[`ULPIRR_S_VVLD]) begin
			vbCode = `ULPIRR_VB_VVLD;
		end else if (st_q.stable[`ULPIRR_S_SVLD]) begin
			vbCode = `ULPIRR_VB_SVLD;
		end else if (st_q.stable[`ULPIRR_S_SEND]) begin
			vbCode = `ULPIRR_VB_LOW;
		end else begin
			vbCode = `ULPIRR_VB_SESS;
		end
		if (rxEvents.hostDisc) begin
			evCode = `ULPIRR_EV_DISC;
		end else if (rxEvents.rxActive && rxEvents.rxError) begin
			evCode = `ULPIRR_EV_ERR;
		end else if (rxEvents.rxActive) begin
			evCode = `ULPIRR_EV_ACT;
		end else begin
			evCode = `ULPIRR_EV_IDLE;
		end
		statusByte = '0;
		statusByte[`ULPIRR_LS_MSB:`ULPIRR_LS_LSB] =
			st_q.stable[`ULPIRR_S_LS_MSB:`ULPIRR_S_LS_LSB];
		statusByte[`ULPIRR_VB_MSB:`ULPIRR_VB_LSB] = vbCode;
		statusByte[`ULPIRR_EV_MSB:`ULPIRR_EV_LSB] = evCode;
		statusByte[`ULPIRR_ID_BIT] = st_q.stable[`ULPIRR_S_ID];
		statusByte[`ULPIRR_ALT_BIT] = rxEvents.altInt;
	end

	a_vbus_code: assert property (
		@(posedge clk) disable iff (!rstn)
		st_q.stable[`ULPIRR_S_VVLD] |->
		statusByte[`ULPIRR_VB_MSB:`ULPIRR_VB_LSB] == `ULPIRR_VB_VVLD)
		else $error("VBUS code wrong above VBUS valid.");

	a_disc_code: assert property (
		@(posedge clk) disable iff (!rstn)
		rxEvents.hostDisc |->
		statusByte[`ULPIRR_EV_MSB:`ULPIRR_EV_LSB] == `ULPIRR_EV_DISC)
		else $error("Host disconnect not encoded.");

endmodule

// *** tb/ulpirr_link_model.sv ***
`timescale 1ns/100ps
`include "ulpirr_defines.svh"

module ulpirr_link_model (
	// Clock
	input wire logic clk,
	// Device side of the bus
	input wire logic dir,
	input wire logic nxt,
	input wire logic [`ULPIRR_W-1:0] dataOut,
	input wire logic dataOeN,
	// Level at the data pins
	output logic [`ULPIRR_W-1:0] pin
);
	logic [`ULPIRR_W-1:0] drv = `ULPIRR_IDLE_CMD;
	logic [`ULPIRR_W-1:0] lastPin = 8'h00;
	logic dirQ = 1'b0;

	// ============================================================
	// Pin level
	// An undriven bus flips every cycle so that no stale value passes.
	assign pin = !dataOeN ? dataOut : (dir || dirQ) ? ~lastPin : drv;
	always @(posedge clk) begin
		lastPin <= pin;
		dirQ <= dir;
	end

	// ============================================================
	// Register read; the command goes out on the next edge whether or not the device has released the bus
	task automatic read(input logic [7:0] cmd, input logic [7:0] ext,
		output logic [7:0] data, output int tNxt, output int tDir,
		output int tOff);
		int k;
		logic sent;
		sent = 1'b0;
		tNxt = 0;
		tDir = 0;
		tOff = 0;
		data = 8'h00;
		@(posedge clk);
		drv <= cmd;
		for (k = 1; k <= 12; k++) begin
			@(posedge clk);
			if (nxt === 1'b1 && tNxt == 0)
				tNxt = k;
			if (dir === 1'b1 && tDir == 0)
				tDir = k;
			if (tDir != 0 && k == tDir + 1)
				data = pin;
			if (tDir != 0 && dir === 1'b0 && tOff == 0)
				tOff = k;
			if (nxt === 1'b1 && cmd[5:0] == `ULPIRR_EXT_ESC && !sent) begin
				drv <= ext;
				sent = 1'b1;
			end else if (nxt === 1'b1 || dir === 1'b1) begin
				drv <= `ULPIRR_IDLE_CMD;
			end
		end
	endtask
endmodule

// *** tb/ulpi_reg_read_and_rxcmd_bench.sv ***
`timescale 1ns/100ps
`include "ulpirr_defines.svh"

`define CHK(what, expv, gotv) \
	begin \
		checksDone++; \
		if ((gotv) !== (expv)) begin \
			$display("wrong value %s expected %0h seen %0h", what, expv, gotv); \
			nErrors++; \
		end \
	end

module ulpi_reg_read_and_rxcmd_bench;
	typedef struct packed {
		logic [5:0] pins;
		logic [3:0] ev;
		logic [7:0] exp;
	} ulpirr_bench_row_s;

	localparam ulpirr_bench_row_s ROWS [5] = '{'{6'h25, 4'h0, 8'h41},
		'{6'h02, 4'h1, 8'h86}, '{6'h2B, 4'h2, 8'h6B},
		'{6'h1C, 4'h0, 8'h0C}, '{6'h31, 4'h0, 8'h4D}};
	localparam logic [7:0] RA [5] = '{8'h00, 8'h3F, 8'h2E, 8'h00, 8'hFF};
	localparam logic [7:0] RD [5] = '{8'h11, 8'h50, 8'h3F, 8'h5A, 8'hA5};

	logic clk, rstn, ce, stp, dir, nxt, dataOeN, clkStable, asyncExit;
	logic rxByteValid, txActive, txHs, regRd, regExt;
	logic [7:0] dataIn, dataOut, rxByte, regAddr, regRdData, b, d;
	ulpirr_pkg::ulpirr_status_s statusPins;
	ulpirr_pkg::ulpirr_rxev_s rxEvents;
	int nErrors = 0;
	int checksDone = 0;
	int cycles = 0;
	int tN, tD, tO, i;
	logic quiet;

	// ============================================================
	// Clock, register file and instances
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	assign regRdData = regExt ? (regAddr ^ 8'h5A) : (regAddr + 8'h11);

	ulpirr_core ulpirr_core_inst (.clk(clk), .rstn(rstn), .ce(ce),
		.stp(stp), .dir(dir), .nxt(nxt), .dataIn(dataIn),
		.dataOut(dataOut), .dataOeN(dataOeN), .clkStable(clkStable),
		.asyncExit(asyncExit), .statusPins(statusPins),
		.rxEvents(rxEvents), .rxByteValid(rxByteValid), .rxByte(rxByte),
		.txActive(txActive), .txHs(txHs), .regRd(regRd),
		.regExt(regExt), .regAddr(regAddr), .regRdData(regRdData));
	ulpirr_link_model ulpirr_link_model_inst (.clk(clk), .dir(dir),
		.nxt(nxt), .dataOut(dataOut), .dataOeN(dataOeN), .pin(dataIn));

	// ============================================================
	// Helpers
	task automatic conclude;
		$display("checks %0d errors %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic getStatus(output logic [7:0] v);
		int k;
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			if (dir === 1'b1 && dataOeN === 1'b0 && nxt === 1'b0)
				break;
		end
		v = dataOut;
	endtask

	task automatic settle;
		int k, q;
		q = 0;
		for (k = 0; k < 80 && q < 6; k++) begin
			@(negedge clk);
			q = (dir === 1'b0) ? q + 1 : 0;
		end
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			nErrors++;
			conclude();
		end
	end

	// ============================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		stp = 1'b1;
		clkStable = 1'b0;
		asyncExit = 1'b0;
		statusPins = '0;
		rxEvents = '0;
		rxByteValid = 1'b0;
		rxByte = 8'hA5;
		txActive = 1'b0;
		txHs = 1'b0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		`CHK("dir", 1'b1, dir);
		`CHK("nxt", 1'b0, nxt);
		`CHK("dataOeN", 1'b1, dataOeN);
		`CHK("regRd", 1'b0, regRd);
		`CHK("regAddr", 8'h00, regAddr);
		@(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK("dir boot", 1'b1, dir);
		@(posedge clk);
		clkStable <= 1'b1;
		repeat (6) @(negedge clk);
		`CHK("dir stp high", 1'b0, dir);
		@(posedge clk);
		stp <= 1'b0;
		getStatus(b);
		`CHK("start status", 8'h04, b);
		settle();
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			statusPins <= ROWS[i].pins;
			rxEvents <= ROWS[i].ev;
			getStatus(b);
			`CHK("status row", ROWS[i].exp, b);
			settle();
		end
		@(posedge clk);
		asyncExit <= 1'b1;
		@(posedge clk);
		asyncExit <= 1'b0;
		getStatus(b);
		`CHK("exit status", 8'h4D, b);
		settle();
		for (i = 0; i < 5; i++) begin
			ulpirr_link_model_inst.read(i > 2 ? 8'hEF : {2'h3, RA[i][5:0]},
				RA[i], d, tN, tD, tO);
			`CHK("read nxt edge", 3, tN);
			`CHK("read dir edge", i > 2 ? 5 : 4, tD);
			`CHK("read data", RD[i], d);
			`CHK("read release", i > 2 ? 7 : 6, tO);
			settle();
		end
		@(posedge clk);
		txActive <= 1'b1;
		txHs <= 1'b1;
		statusPins <= 6'h1C;
		quiet = 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (i == 8)
				statusPins <= 6'h25;
			@(negedge clk);
			quiet = quiet && (dir === 1'b0);
		end
		`CHK("held in transmit", 1'b1, quiet);
		@(posedge clk);
		txActive <= 1'b0;
		getStatus(b);
		`CHK("status after tx", 8'h41, b);
		settle();
		@(posedge clk);
		txActive <= 1'b1;
		txHs <= 1'b0;
		statusPins <= 6'h1C;
		quiet = 1'b1;
		repeat (10) begin
			@(negedge clk);
			quiet = quiet && (dir === 1'b0);
		end
		`CHK("held in fs transmit", 1'b1, quiet);
		@(posedge clk);
		stp <= 1'b1;
		getStatus(b);
		`CHK("status on stop", 8'h0C, b);
		@(posedge clk);
		stp <= 1'b0;
		txActive <= 1'b0;
		settle();
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			rxByteValid <= i[0];
			rxEvents <= (i < 8) ? 4'h8 : 4'hC;
			@(negedge clk);
			if (i % 8 >= 3 && dir === 1'b1 && dataOeN === 1'b0) begin
				if (nxt === 1'b1) begin
					`CHK("rx byte", 8'hA5, dataOut);
				end else begin
					`CHK("rx event", i < 8 ? 2'h1 : 2'h3, dataOut[5:4]);
				end
			end
		end
		@(posedge clk);
		rxEvents <= '0;
		rxByteValid <= 1'b0;
		settle();
		`CHK("dir after rx", 1'b0, dir);
		@(posedge clk);
		ce <= 1'b0;
		statusPins <= 6'h25;
		quiet = 1'b1;
		repeat (8) begin
			@(negedge clk);
			quiet = quiet && (dir === 1'b0);
		end
		`CHK("frozen by enable", 1'b1, quiet);
		@(posedge clk);
		ce <= 1'b1;
		getStatus(b);
		`CHK("status after enable", 8'h41, b);
		settle();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK("dir reset", 1'b1, dir);
		`CHK("regAddr reset", 8'h00, regAddr);
		conclude();
	end
endmodule
